// *** include/ccd_map.svh ***
/*
 * Register indices, field positions and reset values of the clock
 * channel divider block.
 * Assumes a 32-bit bus where byte address = 4 * register index.
 */
`ifndef CCD_MAP_SVH
`define CCD_MAP_SVH

// register indices (byte address is four times the index)
`define CCD_IDX_CH0_CNT 10'h190
`define CCD_IDX_CH0_BYP 10'h191
`define CCD_IDX_CH0_DCC 10'h192
`define CCD_IDX_CH1_CNT 10'h196
`define CCD_IDX_CH1_BYP 10'h197
`define CCD_IDX_CH1_DCC 10'h198
`define CCD_IDX_CH2_CNT1 10'h199
`define CCD_IDX_CH2_CNT2 10'h19b
`define CCD_IDX_CH2_BYP 10'h19c
`define CCD_IDX_CH2_DCC 10'h19d
`define CCD_IDX_CH3_CNT1 10'h19e
`define CCD_IDX_CH3_CNT2 10'h1a0
`define CCD_IDX_CH3_BYP 10'h1a1
`define CCD_IDX_CH3_DCC 10'h1a2
`define CCD_IDX_PRESCALE 10'h1e0
`define CCD_IDX_SOURCE 10'h1e1
`define CCD_IDX_STATUS 10'h1e2
`define CCD_IDX_SYNC 10'h1e3

// storage slots of the writable registers
`define CCD_SLOT_CH0_CNT 4'h0
`define CCD_SLOT_CH0_BYP 4'h1
`define CCD_SLOT_CH0_DCC 4'h2
`define CCD_SLOT_CH1_CNT 4'h3
`define CCD_SLOT_CH1_BYP 4'h4
`define CCD_SLOT_CH1_DCC 4'h5
`define CCD_SLOT_CH2_CNT1 4'h6
`define CCD_SLOT_CH2_CNT2 4'h7
`define CCD_SLOT_CH2_BYP 4'h8
`define CCD_SLOT_CH2_DCC 4'h9
`define CCD_SLOT_CH3_CNT1 4'ha
`define CCD_SLOT_CH3_CNT2 4'hb
`define CCD_SLOT_CH3_BYP 4'hc
`define CCD_SLOT_CH3_DCC 4'hd
`define CCD_SLOT_PRESCALE 4'he
`define CCD_SLOT_SOURCE 4'hf

// field positions
`define CCD_HIGH_LSB 0
`define CCD_LOW_LSB 4
`define CCD_BYP_BIT 7
`define CCD_BEGIN_BIT 4
`define CCD_DLY_LSB 0
`define CCD_BYP1_BIT 4
`define CCD_BYP2_BIT 5
`define CCD_DCC_DIS_BIT 0
`define CCD_SYNC_BIT 0

// reset values and prescaler ratio limits
`define CCD_RST_PRESCALE 8'h02
`define CCD_RST_SOURCE 8'h02
`define CCD_RST_OTHER 8'h00
`define CCD_PRE_MIN 3'h2
`define CCD_PRE_MAX 3'h6

`endif

// *** include/ccd_pkg.sv ***
/*
 * Types shared by the clock channel divider modules.
 * Assumes ccd_map.svh supplies the numeric constants.
 */
package ccd_pkg;

  typedef enum logic [1:0] {
    SRC_EXT_PRE,
    SRC_EXT_DIRECT,
    SRC_OSC_PRE,
    SRC_ILLEGAL
  } ccd_src_t;

  typedef enum {
    PH_WAIT,
    PH_HIGH,
    PH_LOW
  } ccd_phase_t;

  typedef logic [7:0] ccd_byte_t;

endpackage : ccd_pkg

// *** hdl/ccd_stage.sv ***
/*
 * One high/low count divider stage working on edge events of its
 * input clock, with bypass, coarse delay and duty fix.
 * Assumes input events are one-cycle pulses from the same clock.
 */
`timescale 1ns/1ps
module ccd_stage import ccd_pkg::*; (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // divider input clock as level and edge events
  input wire logic in_lvl_i,
  input wire logic in_rise_i,
  input wire logic in_fall_i,
  // settings; sync_i loads phase_i, the others are used as they stand
  input wire logic sync_i,
  input wire logic bypass_i,
  input wire logic dcc_dis_i,
  input wire logic [3:0] high_cnt_i,
  input wire logic [3:0] low_cnt_i,
  input wire logic [4:0] phase_i,
  // divided clock
  output logic out_o,
  output logic rise_o,
  output logic fall_o
);

  ccd_phase_t ph_q;
  logic [3:0] cnt_q;
  logic [5:0] dly_q;
  logic fall_pend_q;
  logic prev_q;
  logic odd_ratio;
  logic [5:0] dly_v;

  assign odd_ratio = high_cnt_i[0] ^ low_cnt_i[0];
  assign dly_v = phase_i[4] ?
    {2'h0, phase_i[3:0]} + {2'h0, low_cnt_i} + 6'h01 :
    {2'h0, phase_i[3:0]};

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      out_o <= 1'b0;
      ph_q <= PH_WAIT;
      cnt_q <= 4'h0;
      dly_q <= 6'h00;
      fall_pend_q <= 1'b0;
    end else if (sync_i) begin
      out_o <= phase_i[4];
      ph_q <= PH_WAIT;
      dly_q <= dly_v;
      cnt_q <= 4'h0;
      fall_pend_q <= 1'b0;
    end else if (bypass_i) begin
      out_o <= in_lvl_i;
      ph_q <= PH_WAIT;
      dly_q <= 6'h00;
      fall_pend_q <= 1'b0;
    end else begin
      if (fall_pend_q && in_fall_i) begin
        out_o <= 1'b0;
        fall_pend_q <= 1'b0;
      end
      if (in_rise_i) begin
        case (ph_q)
          PH_WAIT: begin
            if (dly_q != 6'h00) begin
              dly_q <= dly_q - 6'h01;
            end else begin
              out_o <= 1'b1;
              cnt_q <= high_cnt_i;
              ph_q <= PH_HIGH;
            end
          end
          PH_HIGH: begin
            if (cnt_q == 4'h0) begin
              cnt_q <= low_cnt_i;
              ph_q <= PH_LOW;
              if (!dcc_dis_i && odd_ratio) begin
                fall_pend_q <= 1'b1;
              end else begin
                out_o <= 1'b0;
              end
            end else begin
              cnt_q <= cnt_q - 4'h1;
            end
          end
          PH_LOW: begin
            // ratio high plus low plus two
            if (cnt_q == 4'h0) begin
              out_o <= 1'b1;
              fall_pend_q <= 1'b0;
              cnt_q <= high_cnt_i;
              ph_q <= PH_HIGH;
            end else begin
              cnt_q <= cnt_q - 4'h1;
            end
          end
          default: begin
            ph_q <= PH_WAIT;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= out_o;
    end
  end

  assign rise_o = out_o & ~prev_q;
  assign fall_o = ~out_o & prev_q;

endmodule : ccd_stage

// *** hdl/ccd_top.sv ***
/*
 * Clock channel divider: source select, prescaler, two single-stage
 * channels with coarse delay and two two-stage channels, behind an
 * Avalon-MM slave with waitrequest.
 * Assumes source clocks far below CLK_I; they arrive as pins and are
 * sampled, so every output edge lands on a CLK_I edge.
 */
//
// How it works
// - output ratio is prescale times channel
// - prescaler ratio field selects two to six
// - high count plus one, low count plus one
// - channel ratio is high plus low plus two
// - bypass bit divides by one, stage idle
// - dividers count the routed input clock
// - duty fix on by default, per-channel disable
// - raw duty is high count share of ratio
// - bypassed channel shows prescaler duty
// - fix stretches odd prescaler high by the source high time
// - fix on odd channel stretches by the input high time
// - direct path passes input duty, prescaler fix unused
// - direct routes keep source duty
// - mixed channels cascade two dividers
// - single-stage channels have coarse delay
// - begin flag adds low count plus one to delay
// - two-bit source code picks clock path
`timescale 1ns/1ps
`include "ccd_map.svh"
module ccd_top import ccd_pkg::*; (
  // clock and reset
  input wire logic CLK_I,
  input wire logic SRST_I,
  // source clock pins
  input wire logic EXT_CLK_I,
  input wire logic OSC_CLK_I,
  // avalon-mm slave
  input wire logic [11:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  // divided clocks
  output logic [1:0] DIFFERENTIAL_OUTPUTS_O,
  output logic [1:0] MIXED_OUTPUTS_O
);

  ////////////////////////////////////////////////////////////////////
  // pin sampling: three flops, a change counts when 2nd and 3rd agree

  logic [1:0] pin_in;
  logic [1:0] pin_s1_q;
  logic [1:0] pin_s2_q;
  logic [1:0] pin_s3_q;
  logic [1:0] pin_lvl_q;
  logic [1:0] pin_rise;
  logic [1:0] pin_fall;

  assign pin_in = {OSC_CLK_I, EXT_CLK_I};

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      pin_s1_q <= 2'h0;
      pin_s2_q <= 2'h0;
      pin_s3_q <= 2'h0;
    end else begin
      pin_s1_q <= pin_in;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  genvar gp;
  generate
    for (gp = 0; gp < 2; gp++) begin : g_pin
      always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
          pin_lvl_q[gp] <= 1'b0;
        end else if (pin_s2_q[gp] == pin_s3_q[gp]) begin
          pin_lvl_q[gp] <= pin_s3_q[gp];
        end
      end
      assign pin_rise[gp] = (pin_s2_q[gp] == pin_s3_q[gp]) &
        pin_s3_q[gp] & ~pin_lvl_q[gp];
      assign pin_fall[gp] = (pin_s2_q[gp] == pin_s3_q[gp]) &
        ~pin_s3_q[gp] & pin_lvl_q[gp];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // register file: programmed values and the copy in use

  ccd_byte_t reg_q [0:15];
  ccd_byte_t act_q [0:15];
  logic sync_req_q;
  logic sync_go_q;
  logic ack_q;
  logic req;
  logic [9:0] idx;
  logic slot_hit;
  logic [3:0] slot;
  logic wr_take;
  logic src_bad;

  assign idx = AVS_ADDRESS_I[11:2];

  always_comb begin
    slot_hit = 1'b1;
    case (idx)
      `CCD_IDX_CH0_CNT: slot = `CCD_SLOT_CH0_CNT;
      `CCD_IDX_CH0_BYP: slot = `CCD_SLOT_CH0_BYP;
      `CCD_IDX_CH0_DCC: slot = `CCD_SLOT_CH0_DCC;
      `CCD_IDX_CH1_CNT: slot = `CCD_SLOT_CH1_CNT;
      `CCD_IDX_CH1_BYP: slot = `CCD_SLOT_CH1_BYP;
      `CCD_IDX_CH1_DCC: slot = `CCD_SLOT_CH1_DCC;
      `CCD_IDX_CH2_CNT1: slot = `CCD_SLOT_CH2_CNT1;
      `CCD_IDX_CH2_CNT2: slot = `CCD_SLOT_CH2_CNT2;
      `CCD_IDX_CH2_BYP: slot = `CCD_SLOT_CH2_BYP;
      `CCD_IDX_CH2_DCC: slot = `CCD_SLOT_CH2_DCC;
      `CCD_IDX_CH3_CNT1: slot = `CCD_SLOT_CH3_CNT1;
      `CCD_IDX_CH3_CNT2: slot = `CCD_SLOT_CH3_CNT2;
      `CCD_IDX_CH3_BYP: slot = `CCD_SLOT_CH3_BYP;
      `CCD_IDX_CH3_DCC: slot = `CCD_SLOT_CH3_DCC;
      `CCD_IDX_PRESCALE: slot = `CCD_SLOT_PRESCALE;
      `CCD_IDX_SOURCE: slot = `CCD_SLOT_SOURCE;
      default: begin
        slot = 4'h0;
        slot_hit = 1'b0;
      end
    endcase
  end

  // one wait state: request seen, answered on the next edge
  assign req = AVS_READ_I | AVS_WRITE_I;
  assign AVS_WAITREQUEST_O = req & ~ack_q;
  assign wr_take = AVS_WRITE_I & ack_q & AVS_BYTEENABLE_I[0];

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      for (int i = 0; i < 16; i++) begin
        reg_q[i] <= `CCD_RST_OTHER;
      end
      reg_q[`CCD_SLOT_PRESCALE] <= `CCD_RST_PRESCALE;
      reg_q[`CCD_SLOT_SOURCE] <= `CCD_RST_SOURCE;
    end else if (wr_take && slot_hit) begin
      reg_q[slot] <= AVS_WRITEDATA_I[7:0];
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      for (int i = 0; i < 16; i++) begin
        act_q[i] <= `CCD_RST_OTHER;
      end
      act_q[`CCD_SLOT_PRESCALE] <= `CCD_RST_PRESCALE;
      act_q[`CCD_SLOT_SOURCE] <= `CCD_RST_SOURCE;
    end else if (sync_req_q) begin
      for (int i = 0; i < 16; i++) begin
        act_q[i] <= reg_q[i];
      end
    end
  end

  // sync request, set wins over clear
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      sync_req_q <= 1'b1;
      sync_go_q <= 1'b0;
    end else begin
      sync_go_q <= sync_req_q;
      if (wr_take && idx == `CCD_IDX_SYNC &&
          AVS_WRITEDATA_I[`CCD_SYNC_BIT]) begin
        sync_req_q <= 1'b1;
      end else begin
        sync_req_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      AVS_READDATA_O <= 32'h0000_0000;
    end else if (AVS_READ_I && !ack_q) begin
      if (slot_hit) begin
        AVS_READDATA_O <= {24'h00_0000, reg_q[slot]};
      end else if (idx == `CCD_IDX_STATUS) begin
        AVS_READDATA_O <= {26'h000_0000, src_bad,
          sync_req_q | sync_go_q, MIXED_OUTPUTS_O,
          DIFFERENTIAL_OUTPUTS_O};
      end else begin
        AVS_READDATA_O <= 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // source select and prescaler settings

  ccd_src_t src;
  logic src_lvl;
  logic src_rise;
  logic src_fall;
  logic pre_bypass;
  logic [2:0] pre_ratio;
  logic [3:0] pre_high;
  logic [3:0] pre_low;

  assign src = ccd_src_t'(act_q[`CCD_SLOT_SOURCE][1:0]);
  always_comb begin
    src_bad = 1'b0;
    pre_bypass = 1'b0;
    case (src)
      SRC_EXT_PRE: begin
        src_lvl = pin_lvl_q[0];
        src_rise = pin_rise[0];
        src_fall = pin_fall[0];
      end
      SRC_EXT_DIRECT: begin
        src_lvl = pin_lvl_q[0];
        src_rise = pin_rise[0];
        src_fall = pin_fall[0];
        pre_bypass = 1'b1;
      end
      SRC_OSC_PRE: begin
        src_lvl = pin_lvl_q[1];
        src_rise = pin_rise[1];
        src_fall = pin_fall[1];
      end
      default: begin
        // illegal code: no clock reaches the dividers
        src_lvl = 1'b0;
        src_rise = 1'b0;
        src_fall = 1'b0;
        src_bad = 1'b1;
      end
    endcase
  end

  // ratio two to six, others read as two
  assign pre_ratio =
    (act_q[`CCD_SLOT_PRESCALE][2:0] < `CCD_PRE_MIN ||
     act_q[`CCD_SLOT_PRESCALE][2:0] > `CCD_PRE_MAX) ?
    `CCD_PRE_MIN : act_q[`CCD_SLOT_PRESCALE][2:0];
  assign pre_high = {2'h0, pre_ratio[2:1]} - 4'h1;
  assign pre_low = {1'b0, pre_ratio} - {2'h0, pre_ratio[2:1]} - 4'h1;

  ////////////////////////////////////////////////////////////////////
  // channels; each has its own prescaler copy so that its own duty
  // fix bit governs the odd prescaler stretch, all reset by one sync

  logic [3:0] pre_out;
  logic [3:0] pre_rise;
  logic [3:0] pre_fall;
  logic [3:0] ch_dcc_dis;
  logic [1:0] s1_out;
  logic [1:0] s1_rise;
  logic [1:0] s1_fall;

  assign ch_dcc_dis = {act_q[`CCD_SLOT_CH3_DCC][`CCD_DCC_DIS_BIT],
    act_q[`CCD_SLOT_CH2_DCC][`CCD_DCC_DIS_BIT],
    act_q[`CCD_SLOT_CH1_DCC][`CCD_DCC_DIS_BIT],
    act_q[`CCD_SLOT_CH0_DCC][`CCD_DCC_DIS_BIT]};

  genvar gc;
  generate
    for (gc = 0; gc < 4; gc++) begin : g_pre
      ccd_stage u_pre (
        .clk_i(CLK_I),
        .srst_i(SRST_I),
        .in_lvl_i(src_lvl),
        .in_rise_i(src_rise),
        .in_fall_i(src_fall),
        .sync_i(sync_go_q),
        .bypass_i(pre_bypass),
        .dcc_dis_i(ch_dcc_dis[gc]),
        .high_cnt_i(pre_high),
        .low_cnt_i(pre_low),
        .phase_i(5'h00),
        .out_o(pre_out[gc]),
        .rise_o(pre_rise[gc]),
        .fall_o(pre_fall[gc])
      );
    end
  endgenerate

  ccd_stage u_ch0 (
    .clk_i(CLK_I),
    .srst_i(SRST_I),
    .in_lvl_i(pre_out[0]),
    .in_rise_i(pre_rise[0]),
    .in_fall_i(pre_fall[0]),
    .sync_i(sync_go_q),
    .bypass_i(act_q[`CCD_SLOT_CH0_BYP][`CCD_BYP_BIT]),
    .dcc_dis_i(ch_dcc_dis[0]),
    .high_cnt_i(act_q[`CCD_SLOT_CH0_CNT][`CCD_HIGH_LSB+:4]),
    .low_cnt_i(act_q[`CCD_SLOT_CH0_CNT][`CCD_LOW_LSB+:4]),
    .phase_i({act_q[`CCD_SLOT_CH0_BYP][`CCD_BEGIN_BIT],
      act_q[`CCD_SLOT_CH0_BYP][`CCD_DLY_LSB+:4]}),
    .out_o(DIFFERENTIAL_OUTPUTS_O[0]),
    .rise_o(),
    .fall_o()
  );

  ccd_stage u_ch1 (
    .clk_i(CLK_I),
    .srst_i(SRST_I),
    .in_lvl_i(pre_out[1]),
    .in_rise_i(pre_rise[1]),
    .in_fall_i(pre_fall[1]),
    .sync_i(sync_go_q),
    .bypass_i(act_q[`CCD_SLOT_CH1_BYP][`CCD_BYP_BIT]),
    .dcc_dis_i(ch_dcc_dis[1]),
    .high_cnt_i(act_q[`CCD_SLOT_CH1_CNT][`CCD_HIGH_LSB+:4]),
    .low_cnt_i(act_q[`CCD_SLOT_CH1_CNT][`CCD_LOW_LSB+:4]),
    .phase_i({act_q[`CCD_SLOT_CH1_BYP][`CCD_BEGIN_BIT],
      act_q[`CCD_SLOT_CH1_BYP][`CCD_DLY_LSB+:4]}),
    .out_o(DIFFERENTIAL_OUTPUTS_O[1]),
    .rise_o(),
    .fall_o()
  );

  // two cascaded stages per mixed channel
  generate
    for (gc = 0; gc < 2; gc++) begin : g_mix
      localparam logic [3:0] SC1 =
        gc == 0 ? `CCD_SLOT_CH2_CNT1 : `CCD_SLOT_CH3_CNT1;
      localparam logic [3:0] SC2 =
        gc == 0 ? `CCD_SLOT_CH2_CNT2 : `CCD_SLOT_CH3_CNT2;
      localparam logic [3:0] SBY =
        gc == 0 ? `CCD_SLOT_CH2_BYP : `CCD_SLOT_CH3_BYP;

      ccd_stage u_first (
        .clk_i(CLK_I),
        .srst_i(SRST_I),
        .in_lvl_i(pre_out[gc+2]),
        .in_rise_i(pre_rise[gc+2]),
        .in_fall_i(pre_fall[gc+2]),
        .sync_i(sync_go_q),
        .bypass_i(act_q[SBY][`CCD_BYP1_BIT]),
        .dcc_dis_i(ch_dcc_dis[gc+2]),
        .high_cnt_i(act_q[SC1][`CCD_HIGH_LSB+:4]),
        .low_cnt_i(act_q[SC1][`CCD_LOW_LSB+:4]),
        .phase_i(5'h00),
        .out_o(s1_out[gc]),
        .rise_o(s1_rise[gc]),
        .fall_o(s1_fall[gc])
      );

      ccd_stage u_second (
        .clk_i(CLK_I),
        .srst_i(SRST_I),
        .in_lvl_i(s1_out[gc]),
        .in_rise_i(s1_rise[gc]),
        .in_fall_i(s1_fall[gc]),
        .sync_i(sync_go_q),
        .bypass_i(act_q[SBY][`CCD_BYP2_BIT]),
        .dcc_dis_i(ch_dcc_dis[gc+2]),
        .high_cnt_i(act_q[SC2][`CCD_HIGH_LSB+:4]),
        .low_cnt_i(act_q[SC2][`CCD_LOW_LSB+:4]),
        .phase_i(5'h00),
        .out_o(MIXED_OUTPUTS_O[gc]),
        .rise_o(),
        .fall_o()
      );
    end
  endgenerate

endmodule : ccd_top

// *** bench/ccd_load.sv ***
/*
 * Downstream clock load: measures the divided clocks it receives.
 * Assumes its lines change only on clk_i edges and clk_i is CLK_I.
 */
`timescale 1ns/1ps
module ccd_load (
  // clock
  input wire logic clk_i,
  // divided clocks: diff0, diff1, mixed0, mixed1
  input wire logic [3:0] clk_lines_i,
  // last complete high and low lengths in clk_i cycles
  output logic [3:0][15:0] high_len_o = '0,
  output logic [3:0][15:0] low_len_o = '0,
  // time of the last rise, and edge counts
  output logic [3:0][31:0] rise_at_o = '0,
  output logic [3:0][7:0] edges_o = '0
);
  logic [31:0] now_q = '0;
  logic [3:0] prev_q = '0;
  logic [3:0][15:0] run_q = '0;

  always @(posedge clk_i) begin
    now_q <= now_q + 32'h1;
    prev_q <= clk_lines_i;
    for (int i = 0; i < 4; i++) begin
      if (clk_lines_i[i] !== prev_q[i]) begin
        run_q[i] <= 16'h1;
        edges_o[i] <= edges_o[i] + 8'h1;
        if (prev_q[i]) high_len_o[i] <= run_q[i];
        else low_len_o[i] <= run_q[i];
        if (clk_lines_i[i]) rise_at_o[i] <= now_q;
      end else begin
        run_q[i] <= run_q[i] + 16'h1;
      end
    end
  end
endmodule : ccd_load

// *** bench/ccd_top_checker.sv ***
/*
 * Port-level assertions for the clock channel divider.
 * Assumes it is bound into ccd_top and sees only its ports.
 */
`timescale 1ns/1ps
`include "ccd_map.svh"
module ccd_top_checker (
  // clock and reset
  input wire logic CLK_I,
  input wire logic SRST_I,
  // source pins
  input wire logic EXT_CLK_I,
  input wire logic OSC_CLK_I,
  // bus
  input wire logic [11:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic AVS_WAITREQUEST_O,
  // divided clocks
  input wire logic [1:0] DIFFERENTIAL_OUTPUTS_O,
  input wire logic [1:0] MIXED_OUTPUTS_O
);
  logic ext_q, osc_q;
  logic [7:0] since_ext_q, since_osc_q, since_sync_q;
  logic [1:0] src_prog_q, src_act_q;
  wire logic acc = AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_BYTEENABLE_I[0];
  wire logic [9:0] idx = AVS_ADDRESS_I[11:2];
  // in-flight edges from the old source need time to drain
  wire logic settled = since_sync_q > 8'd24;
  wire logic [3:0] outs = {MIXED_OUTPUTS_O, DIFFERENTIAL_OUTPUTS_O};

  always_ff @(posedge CLK_I) begin
    ext_q <= EXT_CLK_I;
    osc_q <= OSC_CLK_I;
  end

  always_ff @(posedge CLK_I) begin
    if (EXT_CLK_I != ext_q) since_ext_q <= 8'h00;
    else if (since_ext_q != 8'hff) since_ext_q <= since_ext_q + 8'h01;
    if (OSC_CLK_I != osc_q) since_osc_q <= 8'h00;
    else if (since_osc_q != 8'hff) since_osc_q <= since_osc_q + 8'h01;
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      src_prog_q <= 2'h2;
      src_act_q <= 2'h2;
      since_sync_q <= 8'h00;
    end else begin
      if (acc && idx == `CCD_IDX_SOURCE) src_prog_q <= AVS_WRITEDATA_I[1:0];
      if (acc && idx == `CCD_IDX_SYNC && AVS_WRITEDATA_I[0]) begin
        src_act_q <= src_prog_q;
        since_sync_q <= 8'h00;
      end else if (since_sync_q != 8'hff) begin
        since_sync_q <= since_sync_q + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SRST_I);

  AST_WAIT_ONE: assert property ((AVS_READ_I || AVS_WRITE_I) &&
    !$past(AVS_READ_I || AVS_WRITE_I) |->
    AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O)
    else $error("bus answer not after exactly one wait state");
  AST_IDLE_NOWAIT: assert property (!(AVS_READ_I || AVS_WRITE_I) |->
    !AVS_WAITREQUEST_O) else $error("waitrequest high while idle");
  AST_RD_UPPER: assert property (AVS_READ_I && !AVS_WAITREQUEST_O |->
    AVS_READDATA_O[31:8] == 24'h0) else $error("read data upper bits set");
  AST_RD_HOLD: assert property (!(AVS_READ_I && AVS_WAITREQUEST_O) |=>
    $stable(AVS_READDATA_O)) else $error("read data moved without a read");
  AST_RST_QUIET: assert property (
    $fell(SRST_I) |-> (outs == 4'h0) [*3])
    else $error("outputs not quiet after reset release");
  AST_EXT_CAUSE: assert property (
    settled && !src_act_q[1] && $changed(outs) |-> since_ext_q <= 8'd12)
    else $error("output edge without an external clock edge");
  AST_OSC_CAUSE: assert property (
    settled && src_act_q == 2'h2 && $changed(outs) |-> since_osc_q <= 8'd12)
    else $error("output edge without an oscillator edge");
  AST_ILLEGAL_STOP: assert property (
    settled && src_act_q == 2'h3 |-> $stable(outs))
    else $error("output moved with the disallowed source code");

  cover property (AVS_READ_I && !AVS_WAITREQUEST_O);
  cover property (settled && src_act_q == 2'h1 && $changed(outs));
  cover property (settled && src_act_q == 2'h3);
endmodule : ccd_top_checker

bind ccd_top ccd_top_checker ccd_chk_u (
  .CLK_I(CLK_I), .SRST_I(SRST_I), .EXT_CLK_I(EXT_CLK_I),
  .OSC_CLK_I(OSC_CLK_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
  .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
  .AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I),
  .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
  .DIFFERENTIAL_OUTPUTS_O(DIFFERENTIAL_OUTPUTS_O),
  .MIXED_OUTPUTS_O(MIXED_OUTPUTS_O));

// *** bench/testbench.sv ***
/*
 * Register-driven testbench for the clock channel divider.
 * Assumes sources are made here on CLK_I edges, slow enough that
 * every level lasts at least three CLK_I cycles.
 */
`timescale 1ns/1ps
`include "ccd_map.svh"
module testbench;
  logic clk, srst, ext, osc, rd, wr;
  logic [11:0] addr;
  logic [31:0] wdata;
  logic [3:0] be;
  wire logic [31:0] rdata;
  wire logic wreq;
  wire logic [1:0] diff, mixed;
  wire logic [3:0][15:0] hl, ll;
  wire logic [3:0][31:0] ra;
  wire logic [3:0][7:0] ed;
  logic [31:0] ed0;
  logic [7:0] eh;
  int fails, cmp_count, ext_cnt, osc_cnt;
  int ext_hi = 4;
  logic [9:0] fix_idx [4] = '{`CCD_IDX_CH0_DCC, `CCD_IDX_CH1_DCC,
    `CCD_IDX_CH2_DCC, `CCD_IDX_CH3_DCC};

  ccd_top dut_u (.CLK_I(clk), .SRST_I(srst), .EXT_CLK_I(ext),
    .OSC_CLK_I(osc), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(be),
    .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wreq),
    .DIFFERENTIAL_OUTPUTS_O(diff), .MIXED_OUTPUTS_O(mixed));
  ccd_load load_u (.clk_i(clk), .clk_lines_i({mixed, diff}),
    .high_len_o(hl), .low_len_o(ll), .rise_at_o(ra), .edges_o(ed));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // external source: period 8, high ext_hi; oscillator: period 12
  always @(posedge clk) begin
    ext_cnt <= (ext_cnt == 7) ? 0 : ext_cnt + 1;
    ext <= (ext_cnt < ext_hi);
    osc_cnt <= (osc_cnt == 11) ? 0 : osc_cnt + 1;
    osc <= (osc_cnt < 6);
  end

  ////////////////////////////////////////////////////////////////////////////
  task end_sim;
    $display("compares=%0d mismatches=%0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // one access; held until waitrequest is sampled low
  task bus(input logic w, input logic [9:0] i, input logic [7:0] d,
           input logic [3:0] b, output logic [7:0] q);
    int n;
    n = 0;
    addr <= {i, 2'b00};
    wdata <= {24'h0, d};
    be <= b;
    rd <= !w;
    wr <= w;
    @(posedge clk);
    while (wreq !== 1'b0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    // a stall that outlasts the bound is a mismatch
    if (wreq !== 1'b0) begin
      fails++;
      end_sim;
    end
    q = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask : bus

  task wr8(input logic [9:0] i, input logic [7:0] d,
           input logic [3:0] b = 4'h1);
    logic [7:0] q;
    bus(1'b1, i, d, b, q);
  endtask : wr8

  task rd_chk(input logic [9:0] i, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, i, 8'h00, 4'hf, q);
    chk({24'h0, q}, {24'h0, e});
  endtask : rd_chk

  task sync_wait(input int n);
    wr8(`CCD_IDX_SYNC, 8'h01);
    repeat (n) @(posedge clk);
  endtask : sync_wait

  task pulse_chk(input int c, input logic [31:0] h, input logic [31:0] l);
    chk({16'h0, hl[c]}, h);
    chk({16'h0, ll[c]}, l);
  endtask : pulse_chk

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    srst = 1'b1; rd = 1'b0; wr = 1'b0; addr = '0; wdata = '0; be = '0;
    ext = 1'b0; osc = 1'b0; ext_cnt = 0; osc_cnt = 0;
    fails = 0; cmp_count = 0;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd_chk(`CCD_IDX_PRESCALE, 8'h02);
    rd_chk(`CCD_IDX_SOURCE, 8'h02);
    rd_chk(`CCD_IDX_CH0_DCC, 8'h00);
    rd_chk(`CCD_IDX_CH1_BYP, 8'h00);
    rd_chk(`CCD_IDX_SYNC, 8'h00);
    rd_chk(10'h100, 8'h00);
    wr8(`CCD_IDX_CH0_CNT, 8'h5a, 4'h0);
    rd_chk(`CCD_IDX_CH0_CNT, 8'h00);
    wr8(`CCD_IDX_CH0_CNT, 8'h21);
    rd_chk(`CCD_IDX_CH0_CNT, 8'h21);
    wr8(`CCD_IDX_CH1_BYP, 8'h80);
    wr8(`CCD_IDX_CH2_CNT1, 8'h10);
    wr8(`CCD_IDX_CH2_CNT2, 8'h00);
    wr8(`CCD_IDX_CH3_BYP, 8'h30);
    for (int k = 0; k < 4; k++) wr8(fix_idx[k], 8'h01);
    wr8(`CCD_IDX_SOURCE, 8'h00);
    // every prescaler ratio, correction off
    for (int p = 2; p <= 6; p++) begin
      wr8(`CCD_IDX_PRESCALE, 8'(p));
      sync_wait(144 * p + 60);
      pulse_chk(0, 16 * p, 24 * p);
      pulse_chk(1, (p / 2) * 8, p * 8 - (p / 2) * 8);
      pulse_chk(2, 24 * p, 24 * p);
      chk({16'h0, hl[3]} + {16'h0, ll[3]}, p * 8);
    end
    // programmed ratio must wait for a sync
    wr8(`CCD_IDX_PRESCALE, 8'h02);
    repeat (300) @(posedge clk);
    chk({16'h0, hl[3]} + {16'h0, ll[3]}, 32'd48);
    rd_chk(`CCD_IDX_PRESCALE, 8'h02);
    // correction on for channels 0 and 1, source duty 3 of 8
    ext_hi = 3;
    wr8(`CCD_IDX_CH0_DCC, 8'h00);
    wr8(`CCD_IDX_CH1_DCC, 8'h00);
    for (int p = 3; p <= 5; p++) begin
      wr8(`CCD_IDX_PRESCALE, 8'(p));
      sync_wait(120 * p + 60);
      eh = (p % 2) ? 8'((p / 2) * 8 + 3) : 8'(p * 4);
      pulse_chk(1, eh, p * 8 - eh);
      pulse_chk(0, 16 * p + eh, 24 * p - eh);
    end
    // external clock without the prescaler
    wr8(`CCD_IDX_SOURCE, 8'h01);
    sync_wait(200);
    pulse_chk(0, 19, 21);
    pulse_chk(1, 3, 5);
    // coarse delay, plain then with the begin flag
    ext_hi = 4;
    wr8(`CCD_IDX_CH0_DCC, 8'h01);
    wr8(`CCD_IDX_CH1_DCC, 8'h01);
    wr8(`CCD_IDX_CH0_CNT, 8'h43);
    wr8(`CCD_IDX_CH1_CNT, 8'h43);
    for (int k = 0; k < 2; k++) begin
      wr8(`CCD_IDX_CH1_BYP, k ? 8'h11 : 8'h03);
      sync_wait(300);
      chk((ra[1] + 32'd7200 - ra[0]) % 32'd72, k ? 48 : 24);
    end
    // oscillator through the prescaler
    wr8(`CCD_IDX_SOURCE, 8'h02);
    wr8(`CCD_IDX_PRESCALE, 8'h02);
    sync_wait(150);
    chk({16'h0, hl[3]} + {16'h0, ll[3]}, 32'd24);
    // disallowed source code stops every output
    wr8(`CCD_IDX_SOURCE, 8'h03);
    sync_wait(40);
    ed0 = ed;
    repeat (300) @(posedge clk);
    chk(ed, ed0);
    // status: bad source, channel 1 frozen at its begin level
    rd_chk(`CCD_IDX_STATUS, 8'h22);
    end_sim;
  end
endmodule : testbench
